// >>> rsi_pkg.sv
// package and data memory for the reset state initialiser
// assumes one 125 MHz clock and a program memory with one cycle read latency
// Behaviour
// - program counter 12..8 from 0000H low bits
// - program counter 7..0 from vector word 0001H
// - bank enable flag from bit 7 of 0000H
// - interrupt status flag cleared on any reset
// - carry kept from standby, may be arbitrary otherwise
// - stack pointer left undefined by reset
// - data memory kept across standby reset
// - working registers kept across standby reset
// - bank select register cleared on every reset
// - interval timer counter left undefined by reset
// - interval timer mode cleared on every reset
// - event counter count cleared on every reset
// - event counter modulo preset to all ones
// - event counter mode cleared on every reset
// - timer output enable and toggle cleared
// - watch timer mode cleared on every reset
// - reset input ends stop or halt standby
package rsi_pkg;
    localparam int PC_W    = 13;            // program counter width
    localparam int PC_HI_W = 5;             // bits 12..8
    localparam int BYTE_W  = 8;             // program memory word
    localparam int NIB_W   = 4;             // data nibble
    localparam int DM_AW   = 8;             // data memory address
    localparam int BANK_EN_BIT = 7;         // bank enable bit in vector
    localparam logic [PC_W-1:0] VEC_HI_ADDR = 13'h0000;
    localparam logic [PC_W-1:0] VEC_LO_ADDR = 13'h0001;
    localparam logic [BYTE_W-1:0] MOD_RST   = 8'hFF;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [NIB_W-1:0]  NIB_ZERO  = 4'h0;
    // core write selects
    typedef enum logic [3:0] {
        RSI_SEL_PC   = 4'h0,
        RSI_SEL_PSW  = 4'h1,  // data[4]=carry [3:1]=skip [0]=ist
        RSI_SEL_BANK_EN  = 4'h2,
        RSI_SEL_SP   = 4'h3,
        RSI_SEL_BANK_SEL = 4'h4,
        RSI_SEL_IVL_MODE = 4'h5,
        RSI_SEL_TM   = 4'h6,
        RSI_SEL_MOD  = 4'h7,
        RSI_SEL_TOE  = 4'h8,
        RSI_SEL_WATCH = 4'h9,
        RSI_SEL_WREG = 4'hA   // data[6:4]=index [3:0]=value
    } rsi_sel_t;
    // sequencer states
    typedef enum logic [2:0] {
        RSI_ST_RUN   = 3'b000,
        RSI_ST_HOLD  = 3'b001,
        RSI_ST_FHI   = 3'b010,
        RSI_ST_FLO   = 3'b011,
        RSI_ST_LOAD  = 3'b100
    } rsi_state_t;
endpackage : rsi_pkg

`timescale 1ns/100ps
// data memory: no reset, so contents survive any reset
module rsi_mem (
    input  wire logic                       clk_sys_in,
    input  wire logic                       wr_en_in,
    input  wire logic [rsi_pkg::DM_AW-1:0]  addr_in,
    input  wire logic [rsi_pkg::NIB_W-1:0]  wr_data_in,
    output logic      [rsi_pkg::NIB_W-1:0]  rd_data_out
);
    // storage array
    logic [rsi_pkg::NIB_W-1:0] mem_q [0:(1<<rsi_pkg::DM_AW)-1];

    // write and registered read
    always_ff @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem_q[addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_q[addr_in];
    end
endmodule : rsi_mem

// >>> rsi_top.sv
// reset state initialiser: cpu and timer state on external reset
// assumes the core drives writes and standby level on clk_sys_in
`timescale 1ns/100ps
module rsi_top (
    input  wire logic                        clk_sys_in,
    input  wire logic                        nrst_in,
    input  wire logic                        reset_pin_n_in,
    input  wire logic                        standby_stop_in,
    input  wire logic                        standby_halt_in,
    output logic                             standby_exit_out,
    output logic                             from_standby_out,
    output logic                             core_run_out,
    output logic                             prog_rd_out,
    output logic [rsi_pkg::PC_W-1:0]         prog_addr_out,
    input  wire logic [rsi_pkg::BYTE_W-1:0]  prog_data_in,
    input  wire logic                        core_wr_in,
    input  wire logic [3:0]                  core_wr_sel_in,
    input  wire logic [rsi_pkg::PC_W-1:0]    core_wr_data_in,
    input  wire logic                        dm_wr_in,
    input  wire logic [rsi_pkg::DM_AW-1:0]   dm_addr_in,
    input  wire logic [rsi_pkg::NIB_W-1:0]   dm_wr_data_in,
    output logic [rsi_pkg::NIB_W-1:0]        dm_rd_data_out,
    input  wire logic                        ivl_tick_in,
    input  wire logic                        evt_tick_in,
    output logic [rsi_pkg::PC_W-1:0]         program_counter_out,
    output logic                             carry_flag_out,
    output logic [2:0]                       skip_flags_out,
    output logic                             interrupt_status_flag_out,
    output logic                             bank_enable_flag_out,
    output logic [rsi_pkg::BYTE_W-1:0]       stack_pointer_out,
    output logic [rsi_pkg::NIB_W-1:0]        bank_select_register_out,
    output logic [rsi_pkg::BYTE_W-1:0]       interval_timer_counter_out,
    output logic [rsi_pkg::NIB_W-1:0]        interval_timer_mode_out,
    output logic [rsi_pkg::BYTE_W-1:0]       event_counter_count_out,
    output logic [rsi_pkg::BYTE_W-1:0]       event_counter_modulo_out,
    output logic [rsi_pkg::BYTE_W-1:0]       event_counter_mode_out,
    output logic                             timer_output_enable_out,
    output logic                             timer_output_toggle_out,
    output logic [rsi_pkg::BYTE_W-1:0]       watch_timer_mode_out
);
    // reset pin synchroniser
    logic                       rst_meta_q;    // first stage only
    logic                       rst_sync_q;    // 1 = pin asserted
    // sequencer
    rsi_pkg::rsi_state_t        state_q;
    logic                       run;            // core may write
    logic                       pin_rst;        // registers held at reset
    logic                       standby;        // stop or halt
    // state registers
    logic [rsi_pkg::PC_W-1:0]   pc_q;
    logic                       carry_q;
    logic [2:0]                 sk_q;
    logic                       ist_q;
    logic                       bank_en_q;
    logic [rsi_pkg::BYTE_W-1:0] sp_q;
    logic [rsi_pkg::NIB_W-1:0]  bsel_q;
    logic [rsi_pkg::BYTE_W-1:0] icnt_q;
    logic [rsi_pkg::NIB_W-1:0]  imode_q;
    logic [rsi_pkg::BYTE_W-1:0] ecnt_q;
    logic [rsi_pkg::BYTE_W-1:0] tmod_q;
    logic [rsi_pkg::BYTE_W-1:0] tm_q;
    logic                       toe_q;
    logic                       tout_q;
    logic [rsi_pkg::BYTE_W-1:0] watch_q;
    logic                       from_sby_q;
    logic                       exit_q;
    logic [rsi_pkg::NIB_W-1:0]  wreg_q [0:7];   // working registers
    logic                       ecnt_match;

    // core write hit for one select, only while running
    function automatic logic wr_hit(input logic [3:0] sel);
        wr_hit = core_wr_in && run && (core_wr_sel_in == sel);
    endfunction : wr_hit

    assign standby  = standby_stop_in | standby_halt_in;
    assign run      = (state_q == rsi_pkg::RSI_ST_RUN);
    assign pin_rst  = rst_sync_q;

    // two flops on the asynchronous reset pin
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= 1'b1;
        end else begin
            rst_meta_q <= ~reset_pin_n_in;
            rst_sync_q <= rst_meta_q;
        end
    end

    // sequencer: hold, then fetch the two vector bytes
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= rsi_pkg::RSI_ST_HOLD;
        end else if (pin_rst) begin
            state_q <= rsi_pkg::RSI_ST_HOLD;
        end else begin
            unique case (state_q)
                rsi_pkg::RSI_ST_HOLD: state_q <= rsi_pkg::RSI_ST_FHI;
                rsi_pkg::RSI_ST_FHI:  state_q <= rsi_pkg::RSI_ST_FLO;
                rsi_pkg::RSI_ST_FLO:  state_q <= rsi_pkg::RSI_ST_LOAD;
                rsi_pkg::RSI_ST_LOAD: state_q <= rsi_pkg::RSI_ST_RUN;
                rsi_pkg::RSI_ST_RUN:  state_q <= rsi_pkg::RSI_ST_RUN;
                default:              state_q <= rsi_pkg::RSI_ST_HOLD;
            endcase
        end
    end

    // vector read requests, data returns one cycle later
    always_comb begin
        prog_rd_out   = 1'b0;
        prog_addr_out = pc_q;
        if (state_q == rsi_pkg::RSI_ST_FHI) begin
            prog_rd_out   = 1'b1;
            prog_addr_out = rsi_pkg::VEC_HI_ADDR;
        end else if (state_q == rsi_pkg::RSI_ST_FLO) begin
            prog_rd_out   = 1'b1;
            prog_addr_out = rsi_pkg::VEC_LO_ADDR;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            from_sby_q <= 1'b0;
            exit_q     <= 1'b0;
        end else begin
            exit_q <= pin_rst && run && standby;
            if (pin_rst && run) begin
                // remember where the reset came from
                from_sby_q <= standby;
            end
        end
    end

    // program counter and bank enable from the vector
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pc_q  <= '0;
            bank_en_q <= 1'b0;
        end else if (state_q == rsi_pkg::RSI_ST_FLO) begin
            pc_q[rsi_pkg::PC_W-1:rsi_pkg::BYTE_W] <=
                prog_data_in[rsi_pkg::PC_HI_W-1:0];
            bank_en_q <= prog_data_in[rsi_pkg::BANK_EN_BIT];
        end else if (state_q == rsi_pkg::RSI_ST_LOAD) begin
            pc_q[rsi_pkg::BYTE_W-1:0] <= prog_data_in;
        end else if (wr_hit(rsi_pkg::RSI_SEL_PC)) begin
            pc_q <= core_wr_data_in;
        end else if (wr_hit(rsi_pkg::RSI_SEL_BANK_EN)) begin
            bank_en_q <= core_wr_data_in[0];
        end
    end

    // status word flags
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sk_q  <= 3'b000;
            ist_q <= 1'b0;
        end else if (pin_rst) begin
            ist_q <= 1'b0;
            sk_q  <= 3'b000;
        end else if (wr_hit(rsi_pkg::RSI_SEL_PSW)) begin
            sk_q  <= core_wr_data_in[3:1];
            ist_q <= core_wr_data_in[0];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (wr_hit(rsi_pkg::RSI_SEL_PSW)) begin
            carry_q <= core_wr_data_in[4];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (wr_hit(rsi_pkg::RSI_SEL_SP)) begin
            sp_q <= core_wr_data_in[rsi_pkg::BYTE_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (wr_hit(rsi_pkg::RSI_SEL_WREG)) begin
            wreg_q[core_wr_data_in[6:4]] <= core_wr_data_in[3:0];
        end
    end

    // interval counter counts ticks while its mode is nonzero, without reset
    always_ff @(posedge clk_sys_in) begin
        if (ivl_tick_in && (imode_q != rsi_pkg::NIB_ZERO)) begin
            icnt_q <= icnt_q + 8'h01;
        end
    end

    // bank select and interval timer mode
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bsel_q  <= rsi_pkg::NIB_ZERO;
            imode_q <= rsi_pkg::NIB_ZERO;
        end else if (pin_rst) begin
            bsel_q  <= rsi_pkg::NIB_ZERO;
            imode_q <= rsi_pkg::NIB_ZERO;
        end else begin
            if (wr_hit(rsi_pkg::RSI_SEL_BANK_SEL)) begin
                bsel_q <= core_wr_data_in[rsi_pkg::NIB_W-1:0];
            end
            if (wr_hit(rsi_pkg::RSI_SEL_IVL_MODE)) begin
                imode_q <= core_wr_data_in[rsi_pkg::NIB_W-1:0];
            end
        end
    end

    assign ecnt_match = (ecnt_q == tmod_q);

    // event counter count, match reloads zero
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ecnt_q <= rsi_pkg::BYTE_ZERO;
        end else if (pin_rst) begin
            ecnt_q <= rsi_pkg::BYTE_ZERO;
        end else if (evt_tick_in && tm_q[0]) begin
            // mode bit 0 enables counting
            ecnt_q <= ecnt_match ? rsi_pkg::BYTE_ZERO : ecnt_q + 8'h01;
        end
    end

    // event counter modulo and mode, watch mode
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tmod_q <= rsi_pkg::MOD_RST;
            tm_q   <= rsi_pkg::BYTE_ZERO;
            watch_q <= rsi_pkg::BYTE_ZERO;
        end else if (pin_rst) begin
            tmod_q <= rsi_pkg::MOD_RST;
            tm_q   <= rsi_pkg::BYTE_ZERO;
            watch_q <= rsi_pkg::BYTE_ZERO;
        end else begin
            if (wr_hit(rsi_pkg::RSI_SEL_MOD)) begin
                tmod_q <= core_wr_data_in[rsi_pkg::BYTE_W-1:0];
            end
            if (wr_hit(rsi_pkg::RSI_SEL_TM)) begin
                tm_q <= core_wr_data_in[rsi_pkg::BYTE_W-1:0];
            end
            if (wr_hit(rsi_pkg::RSI_SEL_WATCH)) begin
                watch_q <= core_wr_data_in[rsi_pkg::BYTE_W-1:0];
            end
        end
    end

    // timer output enable and toggle flop
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            toe_q  <= 1'b0;
            tout_q <= 1'b0;
        end else if (pin_rst) begin
            toe_q  <= 1'b0;
            tout_q <= 1'b0;
        end else begin
            if (wr_hit(rsi_pkg::RSI_SEL_TOE)) begin
                toe_q <= core_wr_data_in[0];
            end
            if (evt_tick_in && tm_q[0] && ecnt_match && toe_q) begin
                tout_q <= ~tout_q;
            end
        end
    end

    // data memory writes blocked outside run
    rsi_mem u_dmem (
        .clk_sys_in  (clk_sys_in),
        .wr_en_in    (dm_wr_in && run),
        .addr_in     (dm_addr_in),
        .wr_data_in  (dm_wr_data_in),
        .rd_data_out (dm_rd_data_out)
    );

    // outputs
    assign standby_exit_out           = exit_q;
    assign from_standby_out           = from_sby_q;
    assign core_run_out               = run;
    assign program_counter_out        = pc_q;
    assign carry_flag_out             = carry_q;
    assign skip_flags_out             = sk_q;
    assign interrupt_status_flag_out  = ist_q;
    assign bank_enable_flag_out       = bank_en_q;
    assign stack_pointer_out          = sp_q;
    assign bank_select_register_out   = bsel_q;
    assign interval_timer_counter_out = icnt_q;
    assign interval_timer_mode_out    = imode_q;
    assign event_counter_count_out    = ecnt_q;
    assign event_counter_modulo_out   = tmod_q;
    assign event_counter_mode_out     = tm_q;
    assign timer_output_enable_out    = toe_q;
    assign timer_output_toggle_out    = tout_q;
    assign watch_timer_mode_out       = watch_q;

    // checks
    property p_pc_hi;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (state_q == rsi_pkg::RSI_ST_FLO) && !pin_rst |=>
            pc_q[12:8] == $past(prog_data_in[4:0]);
    endproperty
    a_pc_hi: assert property (p_pc_hi)
        else $error("pc high bits not from vector");
    property p_pc_lo;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (state_q == rsi_pkg::RSI_ST_LOAD) && !pin_rst |=>
            core_run_out && pc_q[7:0] == $past(prog_data_in);
    endproperty
    a_pc_lo: assert property (p_pc_lo)
        else $error("pc low byte not from vector");
    property p_bank_en;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (state_q == rsi_pkg::RSI_ST_FLO) && !pin_rst |=>
            bank_en_q == $past(prog_data_in[7]);
    endproperty
    a_bank_en: assert property (p_bank_en)
        else $error("bank enable not from vector bit 7");
    property p_psw;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        pin_rst |=> !ist_q && sk_q == 3'b000;
    endproperty
    a_psw: assert property (p_psw)
        else $error("status flags not cleared");
    property p_carry;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        pin_rst && from_sby_q |=> $stable(carry_q);
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry changed during standby reset");
    property p_fetch;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        $fell(pin_rst) |=> prog_addr_out == 13'h0000 && prog_rd_out
            ##1 pin_rst || (prog_addr_out == 13'h0001 && prog_rd_out);
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("vector fetch order wrong");
    property p_tmr;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        pin_rst |=> bsel_q == 4'h0 && imode_q == 4'h0 && ecnt_q == 8'h00
            && tmod_q == 8'hFF && tm_q == 8'h00 && watch_q == 8'h00;
    endproperty
    a_tmr: assert property (p_tmr)
        else $error("timer registers not initialised");
    property p_tout;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        pin_rst |=> !toe_q && !tout_q;
    endproperty
    a_tout: assert property (p_tout)
        else $error("timer output not cleared");
    property p_exit;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        pin_rst && run && standby |=> standby_exit_out && !core_run_out;
    endproperty
    a_exit: assert property (p_exit)
        else $error("standby not left on reset");
endmodule : rsi_top

// >>> rsi_vec_model.sv
// program memory model that supplies the two reset vector bytes
// assumes one cycle read latency, reads only while the read strobe is high
`timescale 1ns/100ps
module rsi_vec_model (
    input  wire logic                       clk_sys_in,
    input  wire logic                       rd_in,
    input  wire logic [rsi_pkg::PC_W-1:0]   addr_in,
    input  wire logic [rsi_pkg::BYTE_W-1:0] vec_hi_in,
    input  wire logic [rsi_pkg::BYTE_W-1:0] vec_lo_in,
    output logic      [rsi_pkg::BYTE_W-1:0] data_out
);
    logic [rsi_pkg::BYTE_W-1:0] noise_q = 8'hA5;  // junk while idle

    // changing pattern so stale data is never mistaken for a vector
    always_ff @(posedge clk_sys_in) begin
        noise_q <= noise_q + 8'h5B;
    end

    // one cycle read; unknown addresses and idle cycles give junk
    always_ff @(posedge clk_sys_in) begin
        if (rd_in && addr_in == rsi_pkg::VEC_HI_ADDR) begin
            data_out <= vec_hi_in;
        end else if (rd_in && addr_in == rsi_pkg::VEC_LO_ADDR) begin
            data_out <= vec_lo_in;
        end else begin
            data_out <= ~noise_q;
        end
    end
endmodule : rsi_vec_model

// >>> tb.sv
// self-checking bench for the reset state initialiser
// assumes rsi_top and the vector model; clock 125 MHz, no randomness
`timescale 1ns/100ps
module tb;
    logic        clk_sys_in = 1'b0;       // system clock
    logic        nrst_in = 1'b0;          // power-on reset
    logic        rst_pin_n = 1'b1;        // external reset pin
    logic        stop_lvl = 1'b0;         // stop standby level
    logic        halt_lvl = 1'b0;         // halt standby level
    logic        wr = 1'b0;               // core write strobe
    logic [3:0]  wr_sel = 4'h0;           // core write select
    logic [12:0] wr_data = 13'h0000;      // core write data
    logic        dm_wr = 1'b0;            // data memory write
    logic [7:0]  dm_addr = 8'h00;         // data memory address
    logic [3:0]  dm_wdata = 4'h0;         // data memory write data
    logic        ivl_tick = 1'b0;         // interval timer enable
    logic        evt_tick = 1'b0;         // event counter enable
    logic [7:0]  vec_hi = 8'h83;          // vector byte 0000
    logic [7:0]  vec_lo = 8'h5A;          // vector byte 0001
    logic [7:0]  prog_data;               // program memory data
    logic        prog_rd, exit_p, from_sb, run, carry, ist, bank_en, toe, tog;
    logic [12:0] pc, prog_addr;
    logic [2:0]  skip;
    logic [7:0]  sp, btc, cnt, modv, tm, watch;
    logic [3:0]  dm_rd, bank_sel, ivl_mode;
    logic        exit_seen = 1'b0;        // standby exit pulse caught
    int          fail_count = 0;
    int          comparisons = 0;

    // free running clock
    always #4 clk_sys_in = ~clk_sys_in;

    rsi_top rsi_top_inst (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .reset_pin_n_in(rst_pin_n), .standby_stop_in(stop_lvl),
        .standby_halt_in(halt_lvl), .standby_exit_out(exit_p),
        .from_standby_out(from_sb), .core_run_out(run),
        .prog_rd_out(prog_rd), .prog_addr_out(prog_addr),
        .prog_data_in(prog_data), .core_wr_in(wr),
        .core_wr_sel_in(wr_sel), .core_wr_data_in(wr_data),
        .dm_wr_in(dm_wr), .dm_addr_in(dm_addr), .dm_wr_data_in(dm_wdata),
        .dm_rd_data_out(dm_rd), .ivl_tick_in(ivl_tick),
        .evt_tick_in(evt_tick),
        .program_counter_out(pc), .carry_flag_out(carry),
        .skip_flags_out(skip), .interrupt_status_flag_out(ist),
        .bank_enable_flag_out(bank_en), .stack_pointer_out(sp),
        .bank_select_register_out(bank_sel),
        .interval_timer_counter_out(btc),
        .interval_timer_mode_out(ivl_mode), .event_counter_count_out(cnt),
        .event_counter_modulo_out(modv), .event_counter_mode_out(tm),
        .timer_output_enable_out(toe), .timer_output_toggle_out(tog),
        .watch_timer_mode_out(watch));

    rsi_vec_model rsi_vec_model_inst (
        .clk_sys_in(clk_sys_in), .rd_in(prog_rd), .addr_in(prog_addr),
        .vec_hi_in(vec_hi), .vec_lo_in(vec_lo), .data_out(prog_data));

    // latch the one cycle exit pulse
    always @(posedge clk_sys_in) begin
        if (exit_p === 1'b1) begin
            exit_seen <= 1'b1;
        end
    end

    // compare and count
    task automatic check(input string name, input logic [12:0] exp,
                         input logic [12:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : check

    // verdict and end of run
    task automatic tally_and_finish();
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // one core register write
    task automatic core_write(input logic [3:0] sel, input logic [12:0] d);
        @(posedge clk_sys_in);
        wr      <= 1'b1;
        wr_sel  <= sel;
        wr_data <= d;
        @(posedge clk_sys_in);
        wr      <= 1'b0;
    endtask : core_write

    // dirty every resettable register and run the event counter
    task automatic dirty_state();
        core_write(4'h0, 13'h0ABC);       // program counter
        core_write(4'h1, 13'h001F);       // carry, skips, ist all set
        core_write(4'h2, 13'h0001);       // bank enable
        core_write(4'h4, 13'h0005);
        core_write(4'h5, 13'h0003);
        core_write(4'h7, 13'h0002);       // short modulo so it wraps
        core_write(4'h6, 13'h0001);
        core_write(4'h8, 13'h0001);
        core_write(4'h9, 13'h0042);
        @(posedge clk_sys_in);
        evt_tick <= 1'b1;
        ivl_tick <= 1'b1;
        // four counts: wrap at 2 toggles the output, count ends at 1
        repeat (4) @(posedge clk_sys_in);
        evt_tick <= 1'b0;
        ivl_tick <= 1'b0;
        @(negedge clk_sys_in);
        check("timer_output_toggle", 1'b1, tog);
        check("event_counter_count", 8'h01, cnt);
    endtask : dirty_state

    // pulse the reset pin and wait for the core to run again
    task automatic pin_reset(input logic [7:0] hi, input logic [7:0] lo);
        int i;
        @(posedge clk_sys_in);
        vec_hi    <= hi;
        vec_lo    <= lo;
        rst_pin_n <= 1'b0;
        repeat (5) @(posedge clk_sys_in);
        rst_pin_n <= 1'b1;
        for (i = 0; i < 40 && run !== 1'b1; i++) @(negedge clk_sys_in);
        check("core_run", 1'b1, run);
        check("program_counter", {hi[4:0], lo}, pc);
        check("bank_enable_flag", hi[7], bank_en);
    endtask : pin_reset

    // every register the reset clears or presets
    task automatic check_cleared();
        check("interrupt_status_flag", 1'b0, ist);
        check("skip_flags", 3'h0, skip);
        check("bank_select_register", 4'h0, bank_sel);
        check("interval_timer_mode", 4'h0, ivl_mode);
        check("event_counter_count", 8'h00, cnt);
        check("event_counter_modulo", 8'hFF, modv);
        check("event_counter_mode", 8'h00, tm);
        check("timer_output_enable", 1'b0, toe);
        check("timer_output_toggle", 1'b0, tog);
        check("watch_timer_mode", 8'h00, watch);
    endtask : check_cleared

    // reset during operation, vector with bank enable set
    task automatic run_reset_scenario();
        dirty_state();
        pin_reset(8'h9A, 8'h3C);
        check("from_standby", 1'b0, from_sb);
        check_cleared();
    endtask : run_reset_scenario

    // reset from stop or halt keeps carry and data memory
    task automatic standby_reset_scenario(input logic use_stop);
        dirty_state();
        @(posedge clk_sys_in);
        dm_wr     <= 1'b1;
        dm_addr   <= 8'h10;
        dm_wdata  <= use_stop ? 4'hA : 4'h5;
        exit_seen <= 1'b0;
        @(posedge clk_sys_in);
        dm_wr    <= 1'b0;
        stop_lvl <= use_stop;
        halt_lvl <= ~use_stop;
        pin_reset(use_stop ? 8'h65 : 8'h62, use_stop ? 8'hC3 : 8'h3A);
        check("standby_exit", 1'b1, exit_seen);
        check("from_standby", 1'b1, from_sb);
        check("carry_flag", 1'b1, carry);
        check_cleared();
        @(posedge clk_sys_in);
        stop_lvl <= 1'b0;
        halt_lvl <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check("data_memory", use_stop ? 4'hA : 4'h5, dm_rd);
    endtask : standby_reset_scenario

    // watchdog against a hang
    initial begin
        #40000;
        fail_count++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        // let the power-on vector fetch finish before any pin reset
        repeat (8) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check("core_run", 1'b1, run);
        check("program_counter", 13'h035A, pc);
        check("bank_enable_flag", 1'b1, bank_en);
        check_cleared();
        pin_reset(8'h1F, 8'hFF);
        run_reset_scenario();
        standby_reset_scenario(1'b1);
        standby_reset_scenario(1'b0);
        tally_and_finish();
    end
endmodule : tb
